/* File: common/seq_interlock_pkg.sv */
// constants, types and register map of the sequence interlock
package seq_interlock_pkg;
  // ****************************************
  // allocation codes, bit positions in the allocation register
  // ****************************************
  localparam int ALLOC_W = 9;
  localparam int BIT_SERVO_ON = 0;
  localparam int BIT_POS_LIMIT = 1;
  localparam int BIT_NEG_LIMIT = 2;
  localparam int BIT_ESTOP = 3;
  localparam int BIT_PROP_ONLY = 4;
  localparam int BIT_DEV_CLEAR = 5;
  localparam int BIT_REGEN_OK = 6;
  localparam int BIT_AR_SEL0 = 7;
  localparam int BIT_AR_SEL1 = 8;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ALLOC = 8'h04;
  localparam logic [7:0] ADDR_AR_FREQ0 = 8'h08;
  localparam logic [7:0] ADDR_AR_FREQ3 = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam int CTRL_DIR_INVERT = 0;
  localparam int CTRL_TEST_MODE = 1;
  localparam int FREQ_W = 16;
  localparam int AR_COUNT = 4;
  // frequency in 0.1 Hz, 200.0 Hz is the disabling default
  localparam logic [15:0] AR_FREQ_DEFAULT = 16'h07D0;
  localparam logic [8:0] ALLOC_RESET = 9'h1FF;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int SYNC_W = 11;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_DECEL,
    MODE_COAST,
    MODE_HOLD
  } stopMode_e;
  // raw pins, limits, stop and overheat are b-contact (low = off)
  typedef struct packed {
    logic manualReverseCmd;
    logic manualForwardCmd;
    logic arSel1;
    logic arSel0;
    logic regenOk;
    logic devClear;
    logic propOnly;
    logic emergencyStopIn;
    logic negativeLimitIn;
    logic positiveLimitIn;
    logic servoOn;
  } seqPins_s;
  typedef struct packed {
    logic pulseFwdPass;
    logic pulseRevPass;
    logic manFwdPass;
    logic manRevPass;
  } cmdGate_s;
endpackage

/* File: design/servo_sequence_interlock.sv */
// sequence input interlock with ahb-lite register slave
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
module servo_sequence_interlock
  import seq_interlock_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sequence pins, asynchronous
  input wire seqPins_s seqPins,
  // motion core, same clock
  input wire logic motorDir,
  input wire logic zeroSpeed,
  input wire logic pulseValid,
  input wire logic pulseDir,
  // interlock results
  output stopMode_e stopMode,
  output cmdGate_s cmdGate,
  output logic deviationClear,
  output logic propControl,
  output logic ready,
  output logic overtravelDet,
  output logic estopDet,
  output logic [FREQ_W-1:0] antiResFreq,
  output logic antiResEnable
);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q, filt_q;
  logic [SYNC_W-1:0] sync1_d, sync2_d, sync3_d, filt_d;
  seqPins_s pin;

  always_comb begin
    sync1_d = seqPins;
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    // glitch filter: a change counts once stages two and three agree
    filt_d = (filt_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      filt_q <= filt_d;
    end
  end

  assign pin = filt_q;

  // ****************************************
  // register file
  // ****************************************
  logic [1:0] ctrl_q, ctrl_d;
  logic [ALLOC_W-1:0] alloc_q, alloc_d;
  logic [FREQ_W-1:0] arFreq_q [AR_COUNT];
  logic [FREQ_W-1:0] arFreq_d [AR_COUNT];
  logic wrPend_q, wrPend_d;
  logic [7:0] wrAddr_q, wrAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;
  logic addrPhase;

  assign addrPhase = hsel && hready && htrans[1];

  always_comb begin
    ctrl_d = ctrl_q;
    alloc_d = alloc_q;
    arFreq_d = arFreq_q;
    wrPend_d = addrPhase && hwrite;
    wrAddr_d = addrPhase ? haddr : wrAddr_q;
    rdata_d = rdata_q;
    if (wrPend_q) begin
      case (wrAddr_q)
        ADDR_CTRL: ctrl_d = hwdata[1:0];
        ADDR_ALLOC: alloc_d = hwdata[ALLOC_W-1:0];
        default: begin
          for (int i = 0; i < AR_COUNT; i++) begin
            if (wrAddr_q == ADDR_AR_FREQ0 + 8'(4 * i)) begin
              arFreq_d[i] = hwdata[FREQ_W-1:0];
            end
          end
        end
      endcase
    end
    if (addrPhase && !hwrite) begin
      rdata_d = '0;
      case (haddr)
        ADDR_CTRL: rdata_d = {30'h0000_0000, ctrl_q};
        ADDR_ALLOC: rdata_d = {23'h00_0000, alloc_q};
        ADDR_STATUS: rdata_d = status;
        default: begin
          for (int i = 0; i < AR_COUNT; i++) begin
            if (haddr == ADDR_AR_FREQ0 + 8'(4 * i)) begin
              rdata_d = {16'h0000, arFreq_q[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
      alloc_q <= ALLOC_RESET;
      for (int i = 0; i < AR_COUNT; i++) begin
        arFreq_q[i] <= AR_FREQ_DEFAULT;
      end
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      alloc_q <= alloc_d;
      arFreq_q <= arFreq_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait states, always okay
  logic hreadyout_q, hresp_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = rdata_q;

  // ****************************************
  // effective inputs after allocation
  // ****************************************
  logic servoOnEff, posTrip, negTrip, estopTrip, regenTrip;
  logic propEff, devClrEff, testMode, otAny, movePos, moveNeg, runOk;
  logic [1:0] arSel;

  always_comb begin
    // unallocated b-contacts read as never tripped
    servoOnEff = !alloc_q[BIT_SERVO_ON] || pin.servoOn;
    posTrip = alloc_q[BIT_POS_LIMIT] && !pin.positiveLimitIn;
    negTrip = alloc_q[BIT_NEG_LIMIT] && !pin.negativeLimitIn;
    estopTrip = alloc_q[BIT_ESTOP] && !pin.emergencyStopIn;
    regenTrip = alloc_q[BIT_REGEN_OK] && !pin.regenOk;
    propEff = alloc_q[BIT_PROP_ONLY] && pin.propOnly;
    devClrEff = alloc_q[BIT_DEV_CLEAR] && pin.devClear;
    arSel[0] = alloc_q[BIT_AR_SEL0] && pin.arSel0;
    arSel[1] = alloc_q[BIT_AR_SEL1] && pin.arSel1;
    testMode = ctrl_q[CTRL_TEST_MODE];
    otAny = posTrip || negTrip;
    // positive sense follows the direction setting
    movePos = !zeroSpeed && (motorDir ^ ctrl_q[CTRL_DIR_INVERT]);
    moveNeg = !zeroSpeed && !(motorDir ^ ctrl_q[CTRL_DIR_INVERT]);
    runOk = servoOnEff && !estopTrip && !regenTrip && !devClrEff;
  end

  // ****************************************
  // stop priority and command gating
  // ****************************************
  stopMode_e mode_q, mode_d;
  cmdGate_s gate_q, gate_d;
  logic devClr_q, devClr_d, prop_q, prop_d, ready_q, ready_d;
  logic otDet_q, otDet_d, estopDet_q, estopDet_d;
  logic [FREQ_W-1:0] arOut_q, arOut_d;
  logic arEn_q, arEn_d;

  always_comb begin
    // emergency stop with servo on outranks every other condition; with servo off it stops like overheat
    if (estopTrip && servoOnEff) begin
      mode_d = MODE_HOLD;
    end else if (estopTrip || regenTrip || !servoOnEff) begin
      mode_d = zeroSpeed ? MODE_COAST : MODE_DECEL;
    end else if ((posTrip && movePos) || (negTrip && moveNeg)) begin
      mode_d = MODE_DECEL;
    end else begin
      mode_d = MODE_RUN;
    end
    gate_d.pulseFwdPass = pulseValid && pulseDir && runOk && !posTrip;
    gate_d.pulseRevPass = pulseValid && !pulseDir && runOk && !negTrip;
    // manual feed away from a tripped limit only in test mode, never past it
    gate_d.manFwdPass = pin.manualForwardCmd && runOk && !posTrip
      && (testMode || !otAny);
    gate_d.manRevPass = pin.manualReverseCmd && runOk && !negTrip
      && (testMode || !otAny);
    devClr_d = devClrEff || otAny || estopTrip;
    prop_d = propEff;
    ready_d = servoOnEff && !estopTrip && !regenTrip && !otAny;
    otDet_d = otAny;
    estopDet_d = estopTrip;
    arOut_d = arFreq_q[arSel];
    arEn_d = arFreq_q[arSel] != AR_FREQ_DEFAULT;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode_q <= MODE_COAST;
      gate_q <= '0;
      devClr_q <= 1'b0;
      prop_q <= 1'b0;
      ready_q <= 1'b0;
      otDet_q <= 1'b0;
      estopDet_q <= 1'b0;
      arOut_q <= AR_FREQ_DEFAULT;
      arEn_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      gate_q <= gate_d;
      devClr_q <= devClr_d;
      prop_q <= prop_d;
      ready_q <= ready_d;
      otDet_q <= otDet_d;
      estopDet_q <= estopDet_d;
      arOut_q <= arOut_d;
      arEn_q <= arEn_d;
    end
  end

  assign stopMode = mode_q;
  assign cmdGate = gate_q;
  assign deviationClear = devClr_q;
  assign propControl = prop_q;
  assign ready = ready_q;
  assign overtravelDet = otDet_q;
  assign estopDet = estopDet_q;
  assign antiResFreq = arOut_q;
  assign antiResEnable = arEn_q;

  // status snapshot for software
  assign status = {14'h0000, arEn_q, mode_q, estopDet_q, otDet_q, ready_q,
    devClr_q, filt_q};

  // ****************************************
  // checks
  // ****************************************
  property p_otDetect;
    @(posedge clock) disable iff (srst) (posTrip || negTrip) |=> overtravelDet;
  endproperty
  a_otDetect: assert property (p_otDetect) else $error("overtravel not flagged");

  property p_estopDetect;
    @(posedge clock) disable iff (srst) estopTrip |=> estopDet && !ready;
  endproperty
  a_estopDetect: assert property (p_estopDetect) else $error("estop not flagged");

  property p_estopHold;
    @(posedge clock) disable iff (srst)
      (estopTrip && servoOnEff) |=> stopMode == MODE_HOLD && cmdGate == '0;
  endproperty
  a_estopHold: assert property (p_estopHold) else $error("estop not holding");

  property p_devClear;
    @(posedge clock) disable iff (srst)
      (estopTrip || otAny || devClrEff) |=> deviationClear;
  endproperty
  a_devClear: assert property (p_devClear) else $error("deviation not cleared");

  property p_limitBlocks;
    @(posedge clock) disable iff (srst)
      posTrip |=> !cmdGate.pulseFwdPass && !cmdGate.manFwdPass;
  endproperty
  a_limitBlocks: assert property (p_limitBlocks) else $error("limit let command through");

  property p_arSelect;
    @(posedge clock) disable iff (srst)
      arSel == 2'b10 |=> antiResFreq == $past(arFreq_q[2]);
  endproperty
  a_arSelect: assert property (p_arSelect) else $error("wrong anti-resonance pick");

  property p_servoOff;
    @(posedge clock) disable iff (srst)
      !servoOnEff |=> !ready && cmdGate == '0 && stopMode != MODE_RUN;
  endproperty
  a_servoOff: assert property (p_servoOff) else $error("servo off not stopping");

  property p_regenStop;
    @(posedge clock) disable iff (srst)
      (regenTrip && !estopTrip) |=> (stopMode == MODE_COAST) == $past(zeroSpeed);
  endproperty
  a_regenStop: assert property (p_regenStop) else $error("overheat stop wrong");

  property p_devClrBlocks;
    @(posedge clock) disable iff (srst) devClrEff |=> cmdGate == '0;
  endproperty
  a_devClrBlocks: assert property (p_devClrBlocks) else $error("clear let command through");
endmodule

/* File: tb/seq_panel_model.sv */
// limit switch, panel and host pin model
`timescale 1ns/100ps
module seq_panel_model
  import seq_interlock_pkg::*;
(
  // clock
  input wire logic clock,
  // requested levels and shaft state
  input wire seqPins_s want,
  input wire logic zeroSpeed,
  // pins toward the interlock
  output seqPins_s pins
);
  // ****************************************
  // pin levels
  // ****************************************
  seqPins_s pinsNext;
  always_comb begin
    pinsNext = want;
    // host holds p-action off unless servo on and shaft still
    pinsNext.propOnly = want.propOnly & want.servoOn & zeroSpeed;
  end
  // switches change on a rising edge, one clock after the request
  always_ff @(posedge clock) begin
    pins <= pinsNext;
  end
endmodule

/* File: tb/tb_servo_sequence_interlock.sv */
// self-checking bench for the sequence interlock
`timescale 1ns/100ps
module tb_servo_sequence_interlock;
  import seq_interlock_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clock, srst, hsel, hwrite, motorDir, zeroSpeed, pulseValid, pulseDir;
  logic hreadyout, hresp, deviationClear, propControl, ready, overtravelDet, estopDet;
  logic antiResEnable;
  logic [7:0] haddr;
  logic [1:0] htrans, ctrl;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, stExp;
  logic [15:0] antiResFreq, rnd;
  logic [15:0] freq [AR_COUNT];
  logic [8:0] alloc;
  stopMode_e stopMode;
  cmdGate_s cmdGate;
  seqPins_s want, pins;
  int num_errors, checks;
  // hand-picked pin sets: idle, +limit with manual, estop, overheat, clear, servo off
  localparam logic [10:0] CORNER [6] = '{11'h04F, 11'h24D, 11'h047, 11'h00F, 11'h26F,
    11'h04E};

  servo_sequence_interlock dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seqPins(pins),
    .motorDir(motorDir), .zeroSpeed(zeroSpeed), .pulseValid(pulseValid),
    .pulseDir(pulseDir), .stopMode(stopMode), .cmdGate(cmdGate),
    .deviationClear(deviationClear), .propControl(propControl), .ready(ready),
    .overtravelDet(overtravelDet), .estopDet(estopDet), .antiResFreq(antiResFreq),
    .antiResEnable(antiResEnable));
  seq_panel_model panel (.clock(clock), .want(want), .zeroSpeed(zeroSpeed), .pins(pins));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsrNext(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input string n, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  // entered just after a rising edge; one single word transfer
  task automatic ahbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic checkOutputs();
    logic [10:0] m, e;
    logic pT, nT, es, oh, sv, runOk, posDir, rdy, dc;
    logic [1:0] mode;
    logic [15:0] f;
    m = {2'b11, alloc};
    // unallocated inputs take their resting level
    e = (pins & m) | (11'h04F & ~m);
    sv = e[BIT_SERVO_ON];
    pT = !e[BIT_POS_LIMIT];
    nT = !e[BIT_NEG_LIMIT];
    es = !e[BIT_ESTOP];
    oh = !e[BIT_REGEN_OK];
    runOk = sv & !es & !oh & !e[BIT_DEV_CLEAR];
    posDir = motorDir ^ ctrl[CTRL_DIR_INVERT];
    if (es & sv) mode = MODE_HOLD;
    else if (es | oh | !sv) mode = zeroSpeed ? MODE_COAST : MODE_DECEL;
    else if (!zeroSpeed & ((pT & posDir) | (nT & !posDir))) mode = MODE_DECEL;
    else mode = MODE_RUN;
    f = freq[{e[BIT_AR_SEL1], e[BIT_AR_SEL0]}];
    rdy = sv & !es & !oh & !pT & !nT;
    dc = pT | nT | es | e[BIT_DEV_CLEAR];
    stExp = {14'h0000, f != AR_FREQ_DEFAULT, mode, es, pT | nT, rdy, dc, pins};
    check("overtravelDet", 32'(pT | nT), 32'(overtravelDet));
    check("estopDet", 32'(es), 32'(estopDet));
    check("ready", 32'(sv & !es & !oh & !pT & !nT), 32'(ready));
    check("devClear", 32'(pT | nT | es | e[BIT_DEV_CLEAR]), 32'(deviationClear));
    check("stopMode", 32'(mode), 32'(stopMode));
    check("cmdGate", 32'({pulseValid & pulseDir & runOk & !pT,
      pulseValid & !pulseDir & runOk & !nT,
      e[9] & runOk & !pT & (ctrl[CTRL_TEST_MODE] | !(pT | nT)),
      e[10] & runOk & !nT & (ctrl[CTRL_TEST_MODE] | !(pT | nT))}), 32'(cmdGate));
    check("propControl", 32'(e[BIT_PROP_ONLY]), 32'(propControl));
    check("antiResFreq", 32'(f), 32'(antiResFreq));
    check("antiResEnable", 32'(f != AR_FREQ_DEFAULT), 32'(antiResEnable));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // watchdog, run needs about 860 cycles
  // ****************************************
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {srst, hsel, hwrite, motorDir, zeroSpeed, pulseValid, pulseDir} = 7'h40;
    {haddr, htrans, hsize, hwdata} = '0;
    want = 11'h04F;
    rnd = 16'h004A;
    alloc = ALLOC_RESET;
    ctrl = CTRL_RESET;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    ahbXfer(1'b0, ADDR_ALLOC, 32'h0);
    check("allocReset", 32'h0000_01FF, rd);
    ahbXfer(1'b0, ADDR_CTRL, 32'h0);
    check("ctrlReset", 32'h0000_0000, rd);
    ahbXfer(1'b0, 8'h1C, 32'h0);
    check("unmapped", 32'h0000_0000, rd);
    check("hresp", 32'h0000_0000, 32'(hresp));
    for (int k = 0; k < AR_COUNT; k++) begin
      rnd = lfsrNext(rnd);
      freq[k] = (k == 0 || k == 2) ? AR_FREQ_DEFAULT : rnd;
      ahbXfer(1'b1, ADDR_AR_FREQ0 + 8'(4 * k), 32'(freq[k]));
      ahbXfer(1'b0, ADDR_AR_FREQ0 + 8'(4 * k), 32'h0);
      check("arFreq", 32'(freq[k]), rd);
    end
    $display("test registers done");
    for (int i = 0; i < 46; i++) begin
      @(posedge clock);
      rnd = lfsrNext(rnd);
      ctrl = (i < 6) ? {i == 1, 1'b0} : rnd[15:14];
      alloc = (i % 4 == 3) ? rnd[8:0] : ALLOC_RESET;
      ahbXfer(1'b1, ADDR_CTRL, 32'(ctrl));
      ahbXfer(1'b1, ADDR_ALLOC, 32'(alloc));
      ahbXfer(1'b0, ADDR_ALLOC, 32'h0);
      check("allocBack", 32'(alloc), rd);
      rnd = lfsrNext(rnd);
      want <= (i < 6) ? CORNER[i] : rnd[10:0];
      {motorDir, zeroSpeed, pulseValid, pulseDir} <= (i < 6) ? {3'b001, i[0]} : rnd[15:12];
      repeat (8) @(posedge clock);
      @(negedge clock);
      checkOutputs();
      @(posedge clock);
      ahbXfer(1'b0, ADDR_STATUS, 32'h0);
      check("status", stExp, rd);
    end
    $display("test interlock done");
    summarize();
  end
endmodule
